// File: hw/host_fifo_port_access.sv
// Host FIFO port access block and its flip-flop FIFO
module fifo_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_clear,
    input  wire logic                       i_valid,
    output logic                            o_ready,
    input  wire logic [WIDTH-1:0]           i_data,
    output logic                            o_valid,
    input  wire logic                       i_ready,
    output logic [WIDTH-1:0]                o_data,
    output logic [$clog2(DEPTH):0]          o_count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_ready;
    logic             next_valid;
    logic             push;
    logic             pop;

    // Storage has no reset; pointers and the count say what is valid
    assign push   = i_valid & o_ready;
    assign pop    = i_ready & o_valid;
    assign o_data = mem[rd_ptr];

    // Ready and valid are registered from the next count
    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = o_count;
        if (i_clear) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else begin
            if (push) begin
                next_mem[wr_ptr] = i_data;
                next_wr_ptr      = wr_ptr + PW'(1);
            end
            if (pop) begin
                next_rd_ptr = rd_ptr + PW'(1);
            end
            next_count = o_count + CW'(push) - CW'(pop);
        end
        next_ready = next_count != FULL_CNT;
        next_valid = next_count != '0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            o_count <= '0;
            o_ready <= 1'b1;
            o_valid <= 1'b0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            o_count <= next_count;
            o_ready <= next_ready;
            o_valid <= next_valid;
        end
    end

    always_ff @(posedge i_clk) begin
        mem <= next_mem;
    end
endmodule

module host_fifo_port_access
    import host_fifo_pkg::*;
(
    input  wire logic                i_core_clk,
    input  wire logic                i_arst_n,
    input  wire logic                i_bus16,
    input  wire logic                i_rd,
    input  wire logic                i_wr,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [DATA_W-1:0]   i_wdata,
    output logic      [DATA_W-1:0]   o_rdata,
    output logic                     o_rdata_valid,
    output logic                     o_txd_space,
    input  wire logic                i_rxd_valid,
    input  wire logic [DATA_W-1:0]   i_rxd_data,
    output logic                     o_rxd_ready,
    input  wire logic                i_rxs_valid,
    input  wire logic [DATA_W-1:0]   i_rxs_data,
    output logic                     o_rxs_ready,
    input  wire logic                i_txs_valid,
    input  wire logic [DATA_W-1:0]   i_txs_data,
    output logic                     o_txs_ready,
    output logic                     o_txd_valid,
    output logic      [DATA_W-1:0]   o_txd_data,
    input  wire logic                i_txd_ready,
    input  wire logic                i_link_up,
    input  wire logic                i_mac_err
);
    logic                rst_meta;
    logic                rst_n;
    logic                rxd_push, rxd_pop, rxd_valid, rxd_ready, rxd_clr;
    logic                rxs_push, rxs_pop, rxs_valid, rxs_ready;
    logic                txs_push, txs_pop, txs_valid, txs_ready;
    logic                txd_push, txd_pop, txd_valid, txd_ready, txd_clr;
    logic [DATA_W-1:0]   rxd_head, rxs_head, txs_head, txd_head, txd_in;
    logic [LVL_W-1:0]    rxd_cnt, rxs_cnt, txs_cnt, txd_cnt;
    logic                hit_rxd, hit_txd, rd_ev, wr_ev, wr_ctrl, wr_lim, wr_cmd;
    logic                under, over, hi_half;
    logic [DATA_W-1:0]   rd_word;

    logic                ev_wc, ev_rc, err_lh, link_ll, txen, srst;
    logic [LVL_W-1:0]    lim_rxd, lim_rxs, lim_txd;
    logic                next_ev_wc, next_ev_rc, next_err_lh, next_link_ll;
    logic                next_txen, next_srst;
    logic [LVL_W-1:0]    next_lim_rxd, next_lim_rxs, next_lim_txd;
    logic [DATA_W-1:0]   next_rdata, next_txd_data;
    logic                next_rdata_valid, next_txd_valid, next_txd_space;
    logic                next_rxd_ready, next_rxs_ready, next_txs_ready;

    // Reset release through two flops; only the second one is used
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Address decode; data ports take a whole 32-byte window
    assign hit_rxd = i_addr[ADDR_W-1:5] == RXD_WIN;
    assign hit_txd = i_addr[ADDR_W-1:5] == TXD_WIN;
    assign rd_ev   = i_rd & port_hit(i_addr, ADDR_EVENTS);
    // Register writes land only in these four places; other addresses drop them, except the transmit data window, which pushes
    assign wr_ev   = i_wr & port_hit(i_addr, ADDR_EVENTS);
    assign wr_ctrl = i_wr & port_hit(i_addr, ADDR_CTRL);
    assign wr_lim  = i_wr & port_hit(i_addr, ADDR_LIMITS);
    assign wr_cmd  = i_wr & port_hit(i_addr, ADDR_CMD);
    // Receive data reads on a 16-bit bus always return the low half
    assign hi_half = i_addr[1] & ~hit_rxd;

    // Host side movement: one entry per completed access
    assign rxd_pop  = i_rd & hit_rxd & rxd_valid;
    // Status pops on the upper half so a 16-bit host sees both halves
    assign rxs_pop  = i_rd & port_hit(i_addr, ADDR_RXS_POP) & rxs_valid
                      & (~i_bus16 | i_addr[1]);
    assign txs_pop  = i_rd & port_hit(i_addr, ADDR_TXS_POP) & txs_valid
                      & (~i_bus16 | i_addr[1]);
    assign txd_push = i_wr & hit_txd & txd_ready & o_txd_space;
    assign txd_in   = i_bus16 ? {16'h0000, i_wdata[15:0]} : i_wdata;
    assign under    = i_rd & hit_rxd & ~rxd_valid;
    assign over     = i_wr & hit_txd & ~(txd_ready & o_txd_space);

    // Link side movement
    assign rxd_push = i_rxd_valid & o_rxd_ready & rxd_ready;
    assign rxs_push = i_rxs_valid & o_rxs_ready & rxs_ready;
    assign txs_push = i_txs_valid & o_txs_ready & txs_ready;
    assign txd_pop  = txd_valid & txen & (~o_txd_valid | i_txd_ready);
    // Soft reset or a flush command empties a data buffer
    assign rxd_clr  = srst | (wr_cmd & i_wdata[CMD_FLUSH_RXD]);
    assign txd_clr  = srst | (wr_cmd & i_wdata[CMD_FLUSH_TXD]);

    fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxd (
        .i_clk(i_core_clk), .i_rst_n(rst_n), .i_clear(rxd_clr),
        .i_valid(rxd_push), .o_ready(rxd_ready), .i_data(i_rxd_data),
        .o_valid(rxd_valid), .i_ready(rxd_pop), .o_data(rxd_head), .o_count(rxd_cnt)
    );
    fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxs (
        .i_clk(i_core_clk), .i_rst_n(rst_n), .i_clear(srst),
        .i_valid(rxs_push), .o_ready(rxs_ready), .i_data(i_rxs_data),
        .o_valid(rxs_valid), .i_ready(rxs_pop), .o_data(rxs_head), .o_count(rxs_cnt)
    );
    fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txs (
        .i_clk(i_core_clk), .i_rst_n(rst_n), .i_clear(srst),
        .i_valid(txs_push), .o_ready(txs_ready), .i_data(i_txs_data),
        .o_valid(txs_valid), .i_ready(txs_pop), .o_data(txs_head), .o_count(txs_cnt)
    );
    fifo_buf #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txd (
        .i_clk(i_core_clk), .i_rst_n(rst_n), .i_clear(txd_clr),
        .i_valid(txd_push), .o_ready(txd_ready), .i_data(txd_in),
        .o_valid(txd_valid), .i_ready(txd_pop), .o_data(txd_head), .o_count(txd_cnt)
    );

    // Read mux
    always_comb begin
        rd_word = '0;
        // Unmapped and write-only places read as zero
        if (hit_rxd) begin
            rd_word = rxd_valid ? rxd_head : '0;
        end else if (hit_txd) begin
            rd_word = '0;
        end else if (port_hit(i_addr, ADDR_RXS_POP) || port_hit(i_addr, ADDR_RXS_PEEK)) begin
            rd_word = rxs_valid ? rxs_head : '0;
        end else if (port_hit(i_addr, ADDR_TXS_POP) || port_hit(i_addr, ADDR_TXS_PEEK)) begin
            rd_word = txs_valid ? txs_head : '0;
        end else if (port_hit(i_addr, ADDR_EVENTS)) begin
            rd_word = {28'h0000000, link_ll, err_lh, ev_rc, ev_wc};
        end else if (port_hit(i_addr, ADDR_CTRL)) begin
            rd_word = {30'h0, txen, 1'b0};
        end else if (port_hit(i_addr, ADDR_LIMITS)) begin
            rd_word = {11'h0, lim_txd, 3'h0, lim_rxs, 3'h0, lim_rxd};
        end else if (port_hit(i_addr, ADDR_CMD)) begin
            rd_word = '0;
        end else if (port_hit(i_addr, ADDR_LEVELS)) begin
            rd_word = {3'h0, txs_cnt, 3'h0, txd_cnt, 3'h0, rxs_cnt, 3'h0, rxd_cnt};
        end
    end

    // Room for one more entry under both the programmed limit and the real depth
    function automatic logic has_room(input logic [LVL_W-1:0] lvl,
                                      input logic [LVL_W-1:0] lim);
        return (lvl < lim) && (lvl < DEPTH_LVL);
    endfunction

    always_comb begin
        next_rdata       = i_rd ? half_sel(rd_word, i_bus16, hi_half) : o_rdata;
        next_rdata_valid = i_rd;
        // Event set wins over a same-cycle clear
        next_ev_wc   = (ev_wc & ~(wr_ev & i_wdata[EV_UNDER_BIT])) | under;
        next_ev_rc   = (ev_rc & ~rd_ev) | over;
        next_err_lh  = rd_ev ? i_mac_err : (err_lh | i_mac_err);
        next_link_ll = rd_ev ? i_link_up : (link_ll & i_link_up);
        next_txen    = wr_ctrl ? i_wdata[CTRL_TXEN_BIT] : txen;
        next_srst    = wr_ctrl & i_wdata[CTRL_SRST_BIT];
        next_lim_rxd = wr_lim ? i_wdata[RXD_LSB +: LVL_W] : lim_rxd;
        next_lim_rxs = wr_lim ? i_wdata[RXS_LSB +: LVL_W] : lim_rxs;
        next_lim_txd = wr_lim ? i_wdata[TXD_LSB +: LVL_W] : lim_txd;
        next_txd_data  = txd_pop ? txd_head : o_txd_data;
        next_txd_valid = txd_pop | (o_txd_valid & ~i_txd_ready);
        if (srst) begin
            next_ev_wc     = LATCH_RST;
            next_ev_rc     = LATCH_RST;
            next_err_lh    = LATCH_RST;
            next_link_ll   = LATCH_RST;
            next_lim_rxd   = LIMIT_RST;
            next_lim_rxs   = LIMIT_RST;
            next_lim_txd   = LIMIT_RST;
            next_srst      = 1'b0;
            next_txd_valid = 1'b0;
        end
        // Ready flags look one cycle ahead so the registered ready never overruns a limit
        next_rxd_ready = has_room(level_next(rxd_cnt, rxd_push, rxd_pop, rxd_clr), next_lim_rxd);
        next_rxs_ready = has_room(level_next(rxs_cnt, rxs_push, rxs_pop, srst), next_lim_rxs);
        next_txs_ready = has_room(level_next(txs_cnt, txs_push, txs_pop, srst), DEPTH_LVL);
        next_txd_space = has_room(level_next(txd_cnt, txd_push, txd_pop, txd_clr), next_lim_txd);
    end

    // Every output of the block leaves from these flops
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata       <= '0;
            o_rdata_valid <= 1'b0;
            o_txd_valid   <= 1'b0;
            o_txd_data    <= '0;
            o_txd_space   <= 1'b0;
            o_rxd_ready   <= 1'b0;
            o_rxs_ready   <= 1'b0;
            o_txs_ready   <= 1'b0;
            ev_wc         <= LATCH_RST;
            ev_rc         <= LATCH_RST;
            err_lh        <= LATCH_RST;
            link_ll       <= LATCH_RST;
            txen          <= TXEN_RST;
            srst          <= 1'b0;
            lim_rxd       <= LIMIT_RST;
            lim_rxs       <= LIMIT_RST;
            lim_txd       <= LIMIT_RST;
        end else begin
            o_rdata       <= next_rdata;
            o_rdata_valid <= next_rdata_valid;
            o_txd_valid   <= next_txd_valid;
            o_txd_data    <= next_txd_data;
            o_txd_space   <= next_txd_space;
            o_rxd_ready   <= next_rxd_ready;
            o_rxs_ready   <= next_rxs_ready;
            o_txs_ready   <= next_txs_ready;
            ev_wc         <= next_ev_wc;
            ev_rc         <= next_ev_rc;
            err_lh        <= next_err_lh;
            link_ll       <= next_link_ll;
            txen          <= next_txen;
            srst          <= next_srst;
            lim_rxd       <= next_lim_rxd;
            lim_rxs       <= next_lim_rxs;
            lim_txd       <= next_lim_txd;
        end
    end
endmodule

// File: hw/host_fifo_pkg.sv
// Constants, address map and shared helpers for the host FIFO port block
// Functional notes
// - Writes to read-only registers change nothing
// - Write-only registers read back as zero
// - Writing one clears the bit; zero keeps it
// - Clear-on-read bits clear when read
// - Latched bits hold until the register is read
// - Exempt bits survive a software reset
// - Every reset restores all default values, except exempt bits on a software reset
// - Four FIFOs; three have configurable size limits
// - Receive FIFOs are read-only from the host
// - Receive status pop port returns and removes head
// - Receive status peek port returns head, keeps it
// - Each receive data read pops the head
// - Receive data port aliased over eight/sixteen locations
// - Transmit status pop port returns and removes head
// - Transmit status peek port keeps the head
// - Transmit data FIFO is write-only, one push per write
// - Transmit data port aliased over eight/sixteen locations
package host_fifo_pkg;
    localparam int DATA_W     = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int LVL_W      = 5;
    localparam int ADDR_W     = 8;

    localparam logic [2:0]        RXD_WIN        = 3'h0;
    localparam logic [2:0]        TXD_WIN        = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_RXS_POP   = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_RXS_PEEK  = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_TXS_POP   = 8'h48;
    localparam logic [ADDR_W-1:0] ADDR_TXS_PEEK  = 8'h4c;
    localparam logic [ADDR_W-1:0] ADDR_EVENTS    = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h54;
    localparam logic [ADDR_W-1:0] ADDR_LIMITS    = 8'h58;
    localparam logic [ADDR_W-1:0] ADDR_CMD       = 8'h5c;
    localparam logic [ADDR_W-1:0] ADDR_LEVELS    = 8'h60;

    localparam int EV_UNDER_BIT   = 0;
    localparam int EV_OVER_BIT    = 1;
    localparam int CTRL_SRST_BIT  = 0;
    localparam int CTRL_TXEN_BIT  = 1;
    localparam int CMD_FLUSH_RXD  = 0;
    localparam int CMD_FLUSH_TXD  = 1;
    localparam int RXD_LSB        = 0;
    localparam int RXS_LSB        = 8;
    localparam int TXD_LSB        = 16;
    localparam int TXS_LSB        = 24;

    localparam logic [LVL_W-1:0] LIMIT_RST  = 5'h10;
    localparam logic [LVL_W-1:0] DEPTH_LVL  = 5'h10;
    localparam logic             TXEN_RST   = 1'b0;
    localparam logic             LATCH_RST  = 1'b0;

    function automatic logic [LVL_W-1:0] level_next(input logic [LVL_W-1:0] cnt,
                                                    input logic push, input logic pop,
                                                    input logic clr);
        logic [LVL_W-1:0] sum;
        sum = cnt + {{(LVL_W-1){1'b0}}, push} - {{(LVL_W-1){1'b0}}, pop};
        return clr ? '0 : sum;
    endfunction

    function automatic logic port_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
        return addr[ADDR_W-1:2] == base[ADDR_W-1:2];
    endfunction

    function automatic logic [DATA_W-1:0] half_sel(input logic [DATA_W-1:0] word,
                                                   input logic bus16, input logic hi);
        if (!bus16) begin
            return word;
        end
        return hi ? {16'h0000, word[31:16]} : {16'h0000, word[15:0]};
    endfunction
endpackage

// File: dv/host_fifo_port_access_chk.sv
// Checker for host read answers, peek ports and the transmit stream
module host_fifo_port_access_chk
    import host_fifo_pkg::*;
(
    input wire logic              i_core_clk,
    input wire logic              i_arst_n,
    input wire logic              i_rd,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_rdata_valid,
    input wire logic              o_txd_valid,
    input wire logic [DATA_W-1:0] o_txd_data,
    input wire logic              i_txd_ready
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_rd_ans;
        i_rd |=> o_rdata_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_ans;
        !i_rd |=> !o_rdata_valid;
    endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_cmd_zero;
        i_rd && i_addr == ADDR_CMD |=> o_rdata == '0;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command reg read nonzero");
    property p_txwin_zero;
        i_rd && i_addr[7:5] == TXD_WIN |=> o_rdata == '0 && o_rdata_valid;
    endproperty
    a_txwin_zero: assert property (p_txwin_zero) else $error("tx data window readable");
    property p_hold;
        !o_rdata_valid |-> $stable(o_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_peek_rx;
        (i_rd && i_addr == ADDR_RXS_PEEK) ##1 (i_rd && i_addr == ADDR_RXS_PEEK && o_rdata != '0)
            |=> o_rdata == $past(o_rdata);
    endproperty
    a_peek_rx: assert property (p_peek_rx) else $error("rx status peek changed head");
    property p_peek_tx;
        (i_rd && i_addr == ADDR_TXS_PEEK) ##1 (i_rd && i_addr == ADDR_TXS_PEEK && o_rdata != '0)
            |=> o_rdata == $past(o_rdata);
    endproperty
    a_peek_tx: assert property (p_peek_tx) else $error("tx status peek changed head");
    property p_txd_hold;
        o_txd_valid && !i_txd_ready |=> o_txd_valid && $stable(o_txd_data);
    endproperty
    a_txd_hold: assert property (p_txd_hold) else $error("tx word dropped while stalled");

    c_rxd_rd: cover property ((i_rd && i_addr[7:5] == RXD_WIN) ##1 (o_rdata != '0));
    c_txd_go: cover property (o_txd_valid && i_txd_ready);
    c_peek2: cover property ((i_rd && i_addr == ADDR_RXS_PEEK) [*2]);
    c_txd_stall: cover property (o_txd_valid && !i_txd_ready);
endmodule

bind host_fifo_port_access host_fifo_port_access_chk host_fifo_port_access_chk_i (
    .i_core_clk, .i_arst_n, .i_rd, .i_addr, .o_rdata, .o_rdata_valid,
    .o_txd_valid, .o_txd_data, .i_txd_ready);

// File: dv/mac_side_model.sv
// Stream partner standing in for the MAC side of the four FIFOs
module mac_side_model
    import host_fifo_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_stall,
    output logic                   o_rxd_valid,
    output logic      [DATA_W-1:0] o_rxd_data,
    input  wire logic              i_rxd_ready,
    output logic                   o_rxs_valid,
    output logic      [DATA_W-1:0] o_rxs_data,
    input  wire logic              i_rxs_ready,
    output logic                   o_txs_valid,
    output logic      [DATA_W-1:0] o_txs_data,
    input  wire logic              i_txs_ready,
    input  wire logic              i_txd_valid,
    input  wire logic [DATA_W-1:0] i_txd_data,
    output logic                   o_txd_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]        vld = '0;
    logic [DATA_W-1:0] dat [3] = '{default: '0};
    logic [DATA_W-1:0] got [$];
    wire  [2:0]        rdy = {i_txs_ready, i_rxs_ready, i_rxd_ready};
    assign {o_txs_valid, o_rxs_valid, o_rxd_valid} = vld;
    assign o_rxd_data = dat[0];
    assign o_rxs_data = dat[1];
    assign o_txs_data = dat[2];
    initial o_txd_ready = 1'b0;

    // Hold the word until taken, then scramble the bus so stale data is not mistaken
    task send(input int ch, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        vld[ch] <= 1'b1;
        dat[ch] <= d;
        do @(posedge i_clk); while (!rdy[ch]);
        vld[ch] <= 1'b0;
        dat[ch] <= ~d;
    endtask

    always @(posedge i_clk) begin
        o_txd_ready <= !i_stall;
        if (i_txd_valid && o_txd_ready) begin
            got.push_back(i_txd_data);
        end
    end
endmodule

// File: dv/host_fifo_port_access_bench.sv
// Self-checking bench for the host FIFO port block
module host_fifo_port_access_bench
    import host_fifo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              arst_n, host_rd, host_wr, bus16, link_up, mac_err, stall;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, txd_data, rxd_data, rxs_data, txs_data, d, d2;
    logic              rdv, space, rxd_v, rxd_r, rxs_v, rxs_r, txs_v, txs_r, txd_v, txd_r;
    int                error_cnt = 0;
    int                checks = 0;

    always #2 clk = ~clk;

    host_fifo_port_access host_fifo_port_access_i (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_bus16(bus16), .i_rd(host_rd),
        .i_wr(host_wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rdata_valid(rdv), .o_txd_space(space), .i_rxd_valid(rxd_v),
        .i_rxd_data(rxd_data), .o_rxd_ready(rxd_r), .i_rxs_valid(rxs_v),
        .i_rxs_data(rxs_data), .o_rxs_ready(rxs_r), .i_txs_valid(txs_v),
        .i_txs_data(txs_data), .o_txs_ready(txs_r), .o_txd_valid(txd_v),
        .o_txd_data(txd_data), .i_txd_ready(txd_r), .i_link_up(link_up),
        .i_mac_err(mac_err));
    mac_side_model mac_side_model_i (
        .i_clk(clk), .i_stall(stall), .o_rxd_valid(rxd_v), .o_rxd_data(rxd_data),
        .i_rxd_ready(rxd_r), .o_rxs_valid(rxs_v), .o_rxs_data(rxs_data),
        .i_rxs_ready(rxs_r), .o_txs_valid(txs_v), .o_txs_data(txs_data),
        .i_txs_ready(txs_r), .i_txd_valid(txd_v), .i_txd_data(txd_data),
        .o_txd_ready(txd_r));

    task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
        @(posedge clk);
        host_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        host_rd <= 1'b0;
        #1 q = rdata;
    endtask
    // Two reads on consecutive edges
    task rd_two(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q1, q2);
        @(posedge clk);
        host_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        #1 q1 = rdata;
        @(posedge clk);
        host_rd <= 1'b0;
        #1 q2 = rdata;
    endtask
    // Callers keep reserved bits zero and stay off reserved places
    task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        host_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        host_wr <= 1'b0;
    endtask
    // Read one place and compare the bits under a mask
    task rd_expect(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, e);
        logic [DATA_W-1:0] q;
        rd_reg(a, q);
        chk(q & m, e);
    endtask

    task t_defaults;
        rd_expect(ADDR_LIMITS, '1, 32'h0010_1010);
        rd_expect(ADDR_CTRL, '1, 32'h0);
        rd_expect(ADDR_CMD, '1, 32'h0);
        rd_expect(8'h24, '1, 32'h0);
        wr_reg(ADDR_LEVELS, 32'h0000_1f1f);
        rd_expect(ADDR_LEVELS, '1, 32'h0);
        $display("t_defaults done");
    endtask
    task t_rx_data;
        for (int i = 0; i < 3; i++) mac_side_model_i.send(0, 32'ha0 + i);
        wr_reg(8'h04, 32'h0);
        rd_expect(ADDR_LEVELS, '1, 32'h3);
        for (int i = 0; i < 3; i++) begin
            rd_expect(8'(8'h0c * i + 8'h04 * (i / 2)), '1, 32'ha0 + i);
        end
        rd_expect(8'h18, '1, 32'h0);
        rd_expect(ADDR_EVENTS, 32'h1, 32'h1);
        wr_reg(ADDR_EVENTS, 32'h0);
        rd_expect(ADDR_EVENTS, 32'h1, 32'h1);
        wr_reg(ADDR_EVENTS, 32'h1);
        rd_expect(ADDR_EVENTS, 32'h1, 32'h0);
        $display("t_rx_data done");
    endtask
    task t_status(input int ch, input logic [ADDR_W-1:0] pop, peek);
        mac_side_model_i.send(ch, 32'h51 + ch);
        mac_side_model_i.send(ch, 32'h61 + ch);
        wr_reg(pop, 32'h0);
        rd_two(peek, d, d2);
        chk(d, 32'h51 + ch);
        chk(d2, 32'h51 + ch);
        rd_expect(pop, '1, 32'h51 + ch);
        rd_expect(peek, '1, 32'h61 + ch);
        rd_expect(pop, '1, 32'h61 + ch);
        rd_expect(peek, '1, 32'h0);
        $display("t_status done");
    endtask
    task t_tx_data;
        stall <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            host_wr <= 1'b1;
            addr <= 8'h20 + 8'(4 * (i % 8));
            wdata <= 32'hc0 + i;
        end
        @(posedge clk);
        host_wr <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, space}, 32'h0);
        rd_expect(ADDR_LEVELS, '1, 32'h0010_0000);
        wr_reg(8'h3c, 32'hee);
        rd_expect(ADDR_EVENTS, 32'h2, 32'h2);
        rd_expect(ADDR_EVENTS, 32'h2, 32'h0);
        wr_reg(ADDR_CTRL, 32'h2);
        repeat (4) @(posedge clk);
        stall <= 1'b0;
        for (int n = 0; n < 200 && mac_side_model_i.got.size() < 16; n++) @(posedge clk);
        chk(32'(mac_side_model_i.got.size()), 32'h10);
        for (int i = 0; i < 16 && i < mac_side_model_i.got.size(); i++)
            chk(mac_side_model_i.got[i], 32'hc0 + i);
        $display("t_tx_data done");
    endtask
    task t_latched;
        @(posedge clk);
        mac_err <= 1'b1;
        @(posedge clk);
        mac_err <= 1'b0;
        link_up <= 1'b0;
        @(posedge clk);
        link_up <= 1'b1;
        rd_expect(ADDR_EVENTS, 32'hc, 32'h4);
        rd_expect(ADDR_EVENTS, 32'hc, 32'h8);
        $display("t_latched done");
    endtask
    task t_soft_reset;
        wr_reg(ADDR_LIMITS, 32'h0008_0808);
        rd_expect(ADDR_LIMITS, '1, 32'h0008_0808);
        mac_side_model_i.send(0, 32'h77);
        wr_reg(ADDR_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        rd_expect(ADDR_CTRL, '1, 32'h2);
        rd_expect(ADDR_LIMITS, '1, 32'h0010_1010);
        rd_expect(ADDR_LEVELS, '1, 32'h0);
        rd_expect(ADDR_EVENTS, '1, 32'h0);
        $display("t_soft_reset done");
    endtask
    // Halfword host: status pops on the upper half, data ports move low halves
    task t_bus16;
        @(posedge clk);
        bus16 <= 1'b1;
        mac_side_model_i.send(1, 32'h1234_5678);
        mac_side_model_i.send(0, 32'h00ab_cdef);
        rd_expect(ADDR_RXS_POP, '1, 32'h0000_5678);
        rd_expect(ADDR_RXS_POP | 8'h02, '1, 32'h0000_1234);
        rd_expect(ADDR_RXS_PEEK, '1, 32'h0);
        rd_expect(8'h1e, '1, 32'h0000_cdef);
        rd_expect(8'h02, '1, 32'h0);
        wr_reg(8'h22, 32'h5555_aaaa);
        repeat (4) @(posedge clk);
        chk(32'(mac_side_model_i.got.size()), 32'h11);
        chk(mac_side_model_i.got[$], 32'h0000_aaaa);
        bus16 <= 1'b0;
        $display("t_bus16 done");
    endtask

    initial begin
        arst_n = 1'b0;
        host_rd = 1'b0;
        host_wr = 1'b0;
        addr = '0;
        wdata = '0;
        bus16 = 1'b0;
        link_up = 1'b1;
        mac_err = 1'b0;
        stall = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_defaults();
        t_rx_data();
        t_status(1, ADDR_RXS_POP, ADDR_RXS_PEEK);
        t_status(2, ADDR_TXS_POP, ADDR_TXS_PEEK);
        t_tx_data();
        t_latched();
        t_soft_reset();
        t_bus16();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
